// File: src/msc_pkg.sv
`default_nettype none

package msc_pkg;

   // ------------------------------------------------------------------
   // host i/o ports of the index/data pair
   // ------------------------------------------------------------------
   localparam logic [15:0] IO_INDEX_PORT = 16'h00F2;
   localparam logic [15:0] IO_DATA_PORT = 16'h00F3;

   // ------------------------------------------------------------------
   // configuration indexes
   // ------------------------------------------------------------------
   localparam logic [7:0] IDX_MEM_CFG = 8'h00;
   localparam logic [7:0] IDX_DRAM_PAGE = 8'h01;
   localparam logic [7:0] IDX_SHADOW = 8'h02;
   localparam logic [7:0] IDX_COPROC = 8'h03;
   localparam logic [7:0] IDX_MEM_OPT_HI = 8'h12;

   // ------------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] RST_INDEX = 8'h00;
   localparam logic [7:0] RST_MEM_CFG = 8'h00;
   localparam logic [7:0] RST_DRAM_PAGE = 8'h00;
   localparam logic [7:0] RST_SHADOW = 8'h80;
   localparam logic [7:0] RST_COPROC = 8'h00;
   localparam logic [7:0] RST_MEM_OPT_HI = 8'h00;

   // ------------------------------------------------------------------
   // writable bit masks, reserved bits hold and read zero
   // ------------------------------------------------------------------
   localparam logic [7:0] MASK_MEM_CFG = 8'h0F;
   localparam logic [7:0] MASK_DRAM_PAGE = 8'h10;
   localparam logic [7:0] MASK_SHADOW = 8'hFF;
   localparam logic [7:0] MASK_COPROC = 8'h5F;
   localparam logic [7:0] MASK_MEM_OPT_HI = 8'h03;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int BIT_RAS_TO_DIS = 4;
   localparam int BIT_SH_CACHE = 6;
   localparam int BIT_SH_WP = 5;
   localparam int SH_SEG_W = 5;
   localparam int BIT_CBR = 6;
   localparam int BIT_PAR_DIS = 4;
   localparam int BIT_NPX_FAST = 3;
   localparam int BIT_NPX_SEQ_DIS = 2;
   localparam int BIT_FPA_DIS = 1;
   localparam int BIT_NPX_DIS = 0;
   localparam int OPT_LO_W = 4;
   localparam int OPT_W = 6;
   localparam int TOTAL_W = 7;

   // ------------------------------------------------------------------
   // coprocessor wait states and shadow segment bases
   // ------------------------------------------------------------------
   localparam logic [1:0] NPX_WS_FAST = 2'h1;
   localparam logic [1:0] NPX_WS_SLOW = 2'h2;
   localparam logic [3:0] SEG_F = 4'hF;
   localparam logic [3:0] SEG_E = 4'hE;
   localparam logic [3:0] SEG_D = 4'hD;
   localparam logic [3:0] SEG_C = 4'hC;

   // bank population size codes
   typedef enum logic [2:0] {
      SZ_NONE = 3'h0,
      SZ_256K = 3'h1,
      SZ_512K = 3'h2,
      SZ_1M = 3'h3,
      SZ_2M = 3'h4,
      SZ_4M = 3'h5
   } msc_bank_size_type;

endpackage

`default_nettype wire

// File: src/msc_opt_if.sv
`timescale 1ns/1ps
`default_nettype none

// memory option code out, decoded bank layout back
interface msc_opt_if;
   logic [5:0] code;
   logic [3:0][2:0] bank_size;
   logic [6:0] total_mb;
   logic valid;
   modport cfg (output code, input bank_size, input total_mb, input valid);
   modport rom (input code, output bank_size, output total_mb, output valid);
endinterface

`default_nettype wire

// File: src/msc_opt_rom.sv
`timescale 1ns/1ps
`default_nettype none

module msc_opt_rom
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   msc_opt_if.rom opt
);

   localparam logic [2:0] NN = msc_pkg::SZ_NONE;
   localparam logic [2:0] K2 = msc_pkg::SZ_256K;
   localparam logic [2:0] KH = msc_pkg::SZ_512K; // half a megabyte
   localparam logic [2:0] MG = msc_pkg::SZ_1M; // one megabyte
   localparam logic [2:0] M2 = msc_pkg::SZ_2M;
   localparam logic [2:0] M4 = msc_pkg::SZ_4M;

   logic [19:0] row_ff;

   // one table row: valid, total, banks 3..0
   function automatic logic [19:0] ent(
      input logic [6:0] tot,
      input logic [2:0] b0,
      input logic [2:0] b1,
      input logic [2:0] b2,
      input logic [2:0] b3);
      ent = {1'b1, tot, b3, b2, b1, b0};
   endfunction

   // option code to bank layout, unlisted codes decode as empty
   function automatic logic [19:0] lookup(input logic [5:0] code);
      unique case (code)
         6'h00: lookup = ent(7'h01, K2, NN, NN, NN);
         6'h04: lookup = ent(7'h02, K2, K2, NN, NN);
         6'h07: lookup = ent(7'h03, K2, K2, K2, NN);
         6'h09: lookup = ent(7'h04, K2, K2, K2, K2);
         6'h10: lookup = ent(7'h04, MG, NN, NN, NN);
         6'h11: lookup = ent(7'h05, K2, MG, NN, NN);
         6'h12: lookup = ent(7'h06, K2, K2, MG, NN);
         6'h13: lookup = ent(7'h07, K2, K2, K2, MG);
         6'h14: lookup = ent(7'h08, MG, MG, NN, NN);
         6'h15: lookup = ent(7'h09, K2, MG, MG, NN);
         6'h16: lookup = ent(7'h0A, K2, K2, MG, MG);
         6'h17: lookup = ent(7'h0C, MG, MG, MG, NN);
         6'h18: lookup = ent(7'h0D, K2, MG, MG, MG);
         6'h19: lookup = ent(7'h10, MG, MG, MG, MG);
         6'h20: lookup = ent(7'h10, M4, NN, NN, NN);
         6'h21: lookup = ent(7'h14, MG, M4, NN, NN);
         6'h22: lookup = ent(7'h18, MG, MG, M4, NN);
         6'h23: lookup = ent(7'h1C, MG, MG, MG, M4);
         6'h24: lookup = ent(7'h20, M4, M4, NN, NN);
         6'h25: lookup = ent(7'h24, MG, M4, M4, NN);
         6'h26: lookup = ent(7'h28, MG, MG, M4, M4);
         6'h27: lookup = ent(7'h30, M4, M4, M4, NN);
         6'h28: lookup = ent(7'h34, MG, M4, M4, M4);
         6'h29: lookup = ent(7'h40, M4, M4, M4, M4);
         6'h30: lookup = ent(7'h02, KH, NN, NN, NN);
         6'h31: lookup = ent(7'h04, KH, KH, NN, NN);
         6'h32: lookup = ent(7'h06, KH, KH, KH, NN);
         6'h33: lookup = ent(7'h08, KH, KH, KH, KH);
         6'h34: lookup = ent(7'h06, KH, MG, NN, NN);
         6'h35: lookup = ent(7'h08, KH, KH, MG, NN);
         6'h36: lookup = ent(7'h0C, KH, KH, MG, MG);
         6'h37: lookup = ent(7'h12, KH, M4, NN, NN);
         6'h38: lookup = ent(7'h14, KH, KH, M4, NN);
         6'h39: lookup = ent(7'h24, KH, KH, M4, M4);
         6'h02: lookup = ent(7'h12, K2, K2, M4, NN);
         6'h06: lookup = ent(7'h22, K2, K2, M4, M4);
         6'h01: lookup = ent(7'h11, K2, M4, NN, NN);
         6'h3C: lookup = ent(7'h08, M2, NN, NN, NN);
         6'h3D: lookup = ent(7'h10, M2, M2, NN, NN);
         6'h3E: lookup = ent(7'h0C, M2, MG, NN, NN);
         6'h3F: lookup = ent(7'h18, M2, M4, NN, NN);
         default: lookup = 20'h0_0000;
      endcase
   endfunction

   // R1: registered table read
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
         row_ff <= 20'h0_0000;
      else if (ce)
         row_ff <= lookup(opt.code);
   end

   assign opt.valid = row_ff[19];
   assign opt.total_mb = row_ff[18:12];
   assign opt.bank_size = row_ff[11:0];

   chk_option_decode: assert property ( // R1
      @(posedge ref_clk) disable iff (!rst_b)
      ce && opt.code == 6'h29 |=> opt.total_mb == 7'h40 && opt.valid &&
         opt.bank_size == {M4, M4, M4, M4})
      else $error("option 101001 did not decode to four 4M banks");

endmodule

`default_nettype wire

// File: src/msc_config_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: six-bit memory option code decodes into bank sizes and total memory.
// R2: index 1h bit 4 disables row-active timeout; other bits reserved.
// R3: software keeps index 2h bit 7 at one; it resets to one.
// R4: index 2h bit 6 makes enabled shadow segments cacheable.
// R5: index 2h bit 5 write-protects enabled shadow segments.
// R6: index 2h bits 4-0 enable the five shadow segments.
// R7: index 3h bit 6 selects column-before-row expansion-bus refresh.
// R8: index 3h bit 4 suppresses memory parity checking.
// R9: index 3h bit 3 gives one coprocessor wait state, else two.
// R10: index 3h bit 2 disables the coprocessor cycle sequencer.
// R11: index 3h bit 1 routes accelerator accesses to the expansion bus.
// R12: index 3h bit 0 routes coprocessor accesses to the expansion bus.
// R13: index written at port F2, data read or written at port F3.
// R14: software writes zero to reserved and unused bits.
// R15: option code low four bits come from index 0h bits 3-0.

module msc_config_regs
(
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [15:0] io_addr,
   input wire logic io_rd_b,
   input wire logic io_wr_b,
   input wire logic [7:0] io_data_in,
   output logic [7:0] io_data_out_ff,
   output logic io_data_oe_ff,
   input wire logic cpu_mem_valid,
   input wire logic cpu_mem_write,
   input wire logic [19:0] cpu_mem_addr,
   output logic ras_timeout_dis_ff,
   output logic [4:0] shadow_seg_en_ff,
   output logic shadow_cache_en_ff,
   output logic shadow_wp_ff,
   output logic shadow_hit_ff,
   output logic shadow_cacheable_ff,
   output logic shadow_wr_block_ff,
   output logic cbr_refresh_ff,
   output logic parity_check_dis_ff,
   output logic [1:0] npx_wait_states_ff,
   output logic npx_seq_dis_ff,
   output logic fpa_decode_dis_ff,
   output logic npx_decode_dis_ff,
   output logic [3:0][2:0] bank_size,
   output logic [6:0] total_mem_mb,
   output logic option_valid
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   logic [15:0] addr_s1_ff, addr_s2_ff, addr_s3_ff;
   logic [7:0] data_s1_ff, data_s2_ff, data_s3_ff;
   logic rd_b_s1_ff, rd_b_s2_ff;
   logic wr_b_s1_ff, wr_b_s2_ff, wr_b_s3_ff;
   logic [7:0] index_ff;
   logic [7:0] mem_cfg_ff, dram_page_ff, shadow_ff, coproc_ff, opt_hi_ff;
   logic [7:0] nxt_mem_cfg, nxt_dram_page, nxt_shadow, nxt_coproc;
   logic [7:0] nxt_opt_hi;
   logic [7:0] wdat_d1_ff, wdat_d2_ff;
   logic wr_done, wr_index, wr_data, rd_active;
   logic [7:0] wdat, rd_cfg;
   logic [4:0] cpu_seg, cpu_seg_on;
   logic cpu_hit;

   msc_opt_if opt_bus ();

   // merge written bits under mask when the data port hits this index
   function automatic logic [7:0] apply_write(
      input logic [7:0] old_val,
      input logic [7:0] new_val,
      input logic [7:0] mask,
      input logic hit);
      apply_write = hit ? ((new_val & mask) | (old_val & ~mask)) : old_val;
   endfunction

   // which shadow segment a real-mode address falls in, one-hot
   function automatic logic [4:0] seg_of(input logic [19:0] addr);
      seg_of = 5'h00;
      if (addr[19:16] == msc_pkg::SEG_F)
         seg_of = 5'h10;
      else if (addr[19:16] == msc_pkg::SEG_E)
         seg_of = 5'h08;
      else if (addr[19:16] == msc_pkg::SEG_D)
         seg_of = 5'h04;
      else if (addr[19:16] == msc_pkg::SEG_C)
         seg_of = addr[15] ? 5'h02 : 5'h01;
   endfunction

   // ------------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------------

   // two stages before use, a third for strobe edges and held data
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         addr_s1_ff <= 16'h0000;
         addr_s2_ff <= 16'h0000;
         addr_s3_ff <= 16'h0000;
         data_s1_ff <= 8'h00;
         data_s2_ff <= 8'h00;
         data_s3_ff <= 8'h00;
         rd_b_s1_ff <= 1'b1;
         rd_b_s2_ff <= 1'b1;
         wr_b_s1_ff <= 1'b1;
         wr_b_s2_ff <= 1'b1;
         wr_b_s3_ff <= 1'b1;
      end
      else if (ce)
      begin
         addr_s1_ff <= io_addr;
         addr_s2_ff <= addr_s1_ff;
         addr_s3_ff <= addr_s2_ff;
         data_s1_ff <= io_data_in;
         data_s2_ff <= data_s1_ff;
         data_s3_ff <= data_s2_ff;
         rd_b_s1_ff <= io_rd_b;
         rd_b_s2_ff <= rd_b_s1_ff;
         wr_b_s1_ff <= io_wr_b;
         wr_b_s2_ff <= wr_b_s1_ff;
         wr_b_s3_ff <= wr_b_s2_ff;
      end
   end

   // ------------------------------------------------------------------
   // index/data port decode
   // ------------------------------------------------------------------

   // R13: a write takes effect as the strobe is released
   assign wr_done = wr_b_s2_ff & ~wr_b_s3_ff;
   assign wdat = data_s3_ff;
   assign wr_index = wr_done && addr_s3_ff == msc_pkg::IO_INDEX_PORT;
   assign wr_data = wr_done && addr_s3_ff == msc_pkg::IO_DATA_PORT;
   assign rd_active = !rd_b_s2_ff &&
      (addr_s2_ff == msc_pkg::IO_INDEX_PORT ||
       addr_s2_ff == msc_pkg::IO_DATA_PORT);

   // next register values, reserved bits stay zero
   assign nxt_mem_cfg = apply_write(mem_cfg_ff, wdat, msc_pkg::MASK_MEM_CFG,
      wr_data && index_ff == msc_pkg::IDX_MEM_CFG);
   assign nxt_dram_page = apply_write(dram_page_ff, wdat,
      msc_pkg::MASK_DRAM_PAGE, wr_data && index_ff == msc_pkg::IDX_DRAM_PAGE);
   assign nxt_shadow = apply_write(shadow_ff, wdat, msc_pkg::MASK_SHADOW,
      wr_data && index_ff == msc_pkg::IDX_SHADOW);
   assign nxt_coproc = apply_write(coproc_ff, wdat, msc_pkg::MASK_COPROC,
      wr_data && index_ff == msc_pkg::IDX_COPROC);
   assign nxt_opt_hi = apply_write(opt_hi_ff, wdat, msc_pkg::MASK_MEM_OPT_HI,
      wr_data && index_ff == msc_pkg::IDX_MEM_OPT_HI);

   // R13: readback of the selected index, unheld indexes read zero
   assign rd_cfg =
      (index_ff == msc_pkg::IDX_MEM_CFG) ? mem_cfg_ff :
      (index_ff == msc_pkg::IDX_DRAM_PAGE) ? dram_page_ff :
      (index_ff == msc_pkg::IDX_SHADOW) ? shadow_ff :
      (index_ff == msc_pkg::IDX_COPROC) ? coproc_ff :
      (index_ff == msc_pkg::IDX_MEM_OPT_HI) ? opt_hi_ff : 8'h00;

   // ------------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------------

   // R3: shadow register leaves reset with its top bit at one
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         index_ff <= msc_pkg::RST_INDEX;
         mem_cfg_ff <= msc_pkg::RST_MEM_CFG;
         dram_page_ff <= msc_pkg::RST_DRAM_PAGE;
         shadow_ff <= msc_pkg::RST_SHADOW;
         coproc_ff <= msc_pkg::RST_COPROC;
         opt_hi_ff <= msc_pkg::RST_MEM_OPT_HI;
      end
      else if (ce)
      begin
         index_ff <= wr_index ? wdat : index_ff;
         mem_cfg_ff <= nxt_mem_cfg;
         dram_page_ff <= nxt_dram_page;
         shadow_ff <= nxt_shadow;
         coproc_ff <= nxt_coproc;
         opt_hi_ff <= nxt_opt_hi;
      end
   end

   // host data bus, driven only while a port read is in progress
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         io_data_out_ff <= 8'h00;
         io_data_oe_ff <= 1'b0;
      end
      else if (ce)
      begin
         io_data_out_ff <= (addr_s2_ff == msc_pkg::IO_INDEX_PORT) ?
            index_ff : rd_cfg;
         io_data_oe_ff <= rd_active;
      end
   end

   // ------------------------------------------------------------------
   // control outputs
   // ------------------------------------------------------------------

   // R2 R4 R5 R6 R7 R8 R9 R10 R11 R12: registered control fields
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ras_timeout_dis_ff <= 1'b0;
         shadow_seg_en_ff <= 5'h00;
         shadow_cache_en_ff <= 1'b0;
         shadow_wp_ff <= 1'b0;
         cbr_refresh_ff <= 1'b0;
         parity_check_dis_ff <= 1'b0;
         npx_wait_states_ff <= msc_pkg::NPX_WS_SLOW;
         npx_seq_dis_ff <= 1'b0;
         fpa_decode_dis_ff <= 1'b0;
         npx_decode_dis_ff <= 1'b0;
      end
      else if (ce)
      begin
         ras_timeout_dis_ff <= dram_page_ff[msc_pkg::BIT_RAS_TO_DIS];
         shadow_seg_en_ff <= shadow_ff[msc_pkg::SH_SEG_W-1:0];
         shadow_cache_en_ff <= shadow_ff[msc_pkg::BIT_SH_CACHE];
         shadow_wp_ff <= shadow_ff[msc_pkg::BIT_SH_WP];
         cbr_refresh_ff <= coproc_ff[msc_pkg::BIT_CBR];
         parity_check_dis_ff <= coproc_ff[msc_pkg::BIT_PAR_DIS];
         npx_wait_states_ff <= coproc_ff[msc_pkg::BIT_NPX_FAST] ?
            msc_pkg::NPX_WS_FAST : msc_pkg::NPX_WS_SLOW;
         npx_seq_dis_ff <= coproc_ff[msc_pkg::BIT_NPX_SEQ_DIS];
         fpa_decode_dis_ff <= coproc_ff[msc_pkg::BIT_FPA_DIS];
         npx_decode_dis_ff <= coproc_ff[msc_pkg::BIT_NPX_DIS];
      end
   end

   // ------------------------------------------------------------------
   // shadow access qualification
   // ------------------------------------------------------------------

   // R6: only enabled segments count as shadow hits
   assign cpu_seg = seg_of(cpu_mem_addr);
   assign cpu_seg_on = cpu_seg & shadow_seg_en_ff;
   assign cpu_hit = cpu_mem_valid && |cpu_seg_on;

   // R4 R5: cacheability and write blocking of a shadow hit
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         shadow_hit_ff <= 1'b0;
         shadow_cacheable_ff <= 1'b0;
         shadow_wr_block_ff <= 1'b0;
      end
      else if (ce)
      begin
         shadow_hit_ff <= cpu_hit;
         shadow_cacheable_ff <= cpu_hit && shadow_cache_en_ff;
         shadow_wr_block_ff <= cpu_hit && cpu_mem_write && shadow_wp_ff;
      end
   end

   // ------------------------------------------------------------------
   // memory option decode
   // ------------------------------------------------------------------

   // R1 R15: upper two bits from index 12h, lower four from index 0h
   assign opt_bus.code = {opt_hi_ff[1:0], mem_cfg_ff[msc_pkg::OPT_LO_W-1:0]};

   msc_opt_rom u_opt_rom
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .ce(ce),
      .opt(opt_bus.rom)
   );

   assign bank_size = opt_bus.bank_size;
   assign total_mem_mb = opt_bus.total_mb;
   assign option_valid = opt_bus.valid;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------

   // delayed write data, only read by the checks
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wdat_d1_ff <= 8'h00;
         wdat_d2_ff <= 8'h00;
      end
      else
      begin
         wdat_d1_ff <= wdat;
         wdat_d2_ff <= wdat_d1_ff;
      end
   end

   chk_index_load: assert property ( // R13
      @(posedge ref_clk) disable iff (!rst_b)
      ce && wr_index |=> index_ff == wdat_d1_ff)
      else $error("index port write not taken");

   chk_read_drive: assert property ( // R13
      @(posedge ref_clk) disable iff (!rst_b)
      ce && rd_active && addr_s2_ff == msc_pkg::IO_DATA_PORT
      |=> io_data_oe_ff && io_data_out_ff == $past(rd_cfg))
      else $error("data port read not driven with selected register");

   chk_ras_timeout: assert property ( // R2
      @(posedge ref_clk) disable iff (!rst_b)
      (ce && wr_data && index_ff == msc_pkg::IDX_DRAM_PAGE ##1 ce)
      |=> ras_timeout_dis_ff == wdat_d2_ff[msc_pkg::BIT_RAS_TO_DIS])
      else $error("row timeout control does not follow write");

   chk_seg_enable: assert property ( // R6
      @(posedge ref_clk) disable iff (!rst_b)
      (ce && wr_data && index_ff == msc_pkg::IDX_SHADOW ##1 ce)
      |=> shadow_seg_en_ff == wdat_d2_ff[4:0])
      else $error("segment enables do not follow write");

   chk_cache_gate: assert property ( // R4
      @(posedge ref_clk) disable iff (!rst_b)
      ce && cpu_hit |=> shadow_cacheable_ff == $past(shadow_cache_en_ff))
      else $error("shadow cacheability not gated by enable bit");

   chk_write_block: assert property ( // R5
      @(posedge ref_clk) disable iff (!rst_b)
      ce && cpu_hit && cpu_mem_write && shadow_wp_ff |=> shadow_wr_block_ff)
      else $error("write to protected shadow segment not blocked");

   chk_cbr_refresh: assert property ( // R7
      @(posedge ref_clk) disable iff (!rst_b)
      ce && coproc_ff[msc_pkg::BIT_CBR] |=> cbr_refresh_ff)
      else $error("column-before-row refresh not selected");

   chk_parity_off: assert property ( // R8
      @(posedge ref_clk) disable iff (!rst_b)
      ce && !coproc_ff[msc_pkg::BIT_PAR_DIS] |=> !parity_check_dis_ff)
      else $error("parity check suppressed without its bit");

   chk_npx_wait: assert property ( // R9
      @(posedge ref_clk) disable iff (!rst_b)
      ce && !coproc_ff[msc_pkg::BIT_NPX_FAST] |=> npx_wait_states_ff == 2'h2)
      else $error("coprocessor wait states not two with bit clear");

   chk_npx_seq: assert property ( // R10
      @(posedge ref_clk) disable iff (!rst_b)
      ce && coproc_ff[msc_pkg::BIT_NPX_SEQ_DIS] |=> npx_seq_dis_ff)
      else $error("coprocessor sequencer not disabled");

   chk_fpa_route: assert property ( // R11
      @(posedge ref_clk) disable iff (!rst_b)
      ce && coproc_ff[msc_pkg::BIT_FPA_DIS] |=> fpa_decode_dis_ff)
      else $error("accelerator decode not disabled");

   chk_npx_route: assert property ( // R12
      @(posedge ref_clk) disable iff (!rst_b)
      ce && coproc_ff[msc_pkg::BIT_NPX_DIS] |=> npx_decode_dis_ff)
      else $error("coprocessor decode not disabled");

   chk_option_low: assert property ( // R15
      @(posedge ref_clk) disable iff (!rst_b)
      ce && wr_data && index_ff == msc_pkg::IDX_MEM_CFG
      |=> opt_bus.code[3:0] == wdat_d1_ff[3:0])
      else $error("option code low bits do not follow index 0h");

endmodule

`default_nettype wire

// File: tb/msc_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module msc_config_regs_tb;
   // ------------------------------------------------------------
   // stimulus, observed outputs and bench state
   // ------------------------------------------------------------
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic [15:0] io_addr = 16'h0000;
   logic io_rd_b = 1'b1;
   logic io_wr_b = 1'b1;
   logic [7:0] io_data_in = 8'h00;
   logic cpu_mem_valid = 1'b0;
   logic cpu_mem_write = 1'b0;
   logic [19:0] cpu_mem_addr = 20'h0_0000;
   logic [7:0] io_data_out_ff, rd_data, idx, dat;
   logic io_data_oe_ff, ras_timeout_dis_ff, shadow_cache_en_ff, shadow_wp_ff;
   logic shadow_hit_ff, shadow_cacheable_ff, shadow_wr_block_ff;
   logic cbr_refresh_ff, parity_check_dis_ff, npx_seq_dis_ff;
   logic fpa_decode_dis_ff, npx_decode_dis_ff, option_valid;
   logic [4:0] shadow_seg_en_ff;
   logic [1:0] npx_wait_states_ff;
   logic [3:0][2:0] bank_size;
   logic [6:0] total_mem_mb;
   logic [7:0] mdl [0:3] = '{8'h00, 8'h00, 8'h80, 8'h00};
   logic [31:0] lfsr = 32'h0001_319d;
   // option code, valid, total, bank sizes
   logic [25:0] opt [0:4] = '{{6'h29, 1'b1, 7'h40, 12'hb6d},
      {6'h00, 1'b1, 7'h01, 12'h001}, {6'h3e, 1'b1, 7'h0c, 12'h01c},
      {6'h37, 1'b1, 7'h12, 12'h02a}, {6'h1a, 1'b0, 7'h00, 12'h000}};
   // shadow setup, address, write, hit/cacheable/block
   logic [31:0] sh [0:4] = '{{8'hb0, 20'hf_0000, 4'hd},
      {8'hd0, 20'hf_ffff, 4'h6}, {8'hd0, 20'he_0000, 4'h0},
      {8'ha1, 20'hc_7fff, 4'hd}, {8'ha1, 20'hc_8000, 4'h8}};
   int err_count = 0;
   int samples_checked = 0;
   wire logic [14:0] ctl = {ras_timeout_dis_ff, shadow_cache_en_ff,
      shadow_wp_ff, shadow_seg_en_ff, cbr_refresh_ff, parity_check_dis_ff,
      npx_wait_states_ff, npx_seq_dis_ff, fpa_decode_dis_ff, npx_decode_dis_ff};

   msc_config_regs i_msc_config_regs
   (
      .ref_clk, .rst_b, .ce, .io_addr, .io_rd_b, .io_wr_b, .io_data_in,
      .io_data_out_ff, .io_data_oe_ff, .cpu_mem_valid, .cpu_mem_write,
      .cpu_mem_addr, .ras_timeout_dis_ff, .shadow_seg_en_ff,
      .shadow_cache_en_ff, .shadow_wp_ff, .shadow_hit_ff,
      .shadow_cacheable_ff, .shadow_wr_block_ff, .cbr_refresh_ff,
      .parity_check_dis_ff, .npx_wait_states_ff, .npx_seq_dis_ff,
      .fpa_decode_dis_ff, .npx_decode_dis_ff, .bank_size, .total_mem_mb,
      .option_valid
   );

   // ------------------------------------------------------------
   // clock, watchdog and helpers
   // ------------------------------------------------------------
   initial
   begin
      forever #2 ref_clk = ~ref_clk;
   end

   // cuts a hang short well beyond the expected run
   initial
   begin
      #200000;
      err_count++;
      stop_test();
   end

   function automatic logic [31:0] lfsr_step(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // bits each index stores
   function automatic logic [7:0] msk(input logic [7:0] i);
      case (i)
         8'h00: return 8'h0f;
         8'h01: return 8'h10;
         8'h02: return 8'hff;
         8'h03: return 8'h5f;
         8'h12: return 8'h03;
         default: return 8'h00;
      endcase
   endfunction

   // control outputs expected from the register model
   function automatic logic [14:0] ctl_exp();
      return {mdl[1][4], mdl[2][6:0], mdl[3][6], mdl[3][4],
         mdl[3][3] ? 2'h1 : 2'h2, mdl[3][2:0]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one host strobe, address and data held around it
   task automatic io_cyc(input logic [15:0] a, input logic [7:0] d,
      input logic rd);
      @(posedge ref_clk);
      io_addr <= a;
      io_data_in <= d;
      repeat (3) @(posedge ref_clk);
      if (rd)
         io_rd_b <= 1'b0;
      else
         io_wr_b <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rd_data = io_data_out_ff;
      if (rd)
         chk(io_data_oe_ff, 1'b1);
      io_rd_b <= 1'b1;
      io_wr_b <= 1'b1;
      repeat (6) @(posedge ref_clk);
   endtask

   task automatic wr_reg(input logic [7:0] i, input logic [7:0] d);
      io_cyc(16'h00f2, i, 1'b0);
      io_cyc(16'h00f3, d, 1'b0);
      if (i < 8'h04)
         mdl[i[1:0]] = d & msk(i);
   endtask

   task automatic rd_reg(input logic [7:0] i, input logic [7:0] e);
      io_cyc(16'h00f2, i, 1'b0);
      io_cyc(16'h00f3, 8'h00, 1'b1);
      chk(rd_data, e);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst_b <= 1'b1;
      @(posedge ref_clk);
      chk(ctl, ctl_exp());
      for (int i = 1; i < 5; i++)
         rd_reg(8'(i), i == 2 ? 8'h80 : 8'h00);
      $display("reset test done");
      for (int i = 0; i < 24; i++)
      begin
         lfsr = lfsr_step(lfsr);
         idx = 8'(i % 4 + 1);
         dat = (lfsr[7:0] & msk(idx)) | (idx == 8'h02 ? 8'h80 : 8'h00);
         wr_reg(idx, dat);
         rd_reg(idx, dat & msk(idx));
         chk(ctl, ctl_exp());
      end
      $display("register test done");
      // host strobes while the clock enable is low must be ignored
      ce <= 1'b0;
      io_cyc(16'h00f2, 8'h03, 1'b0);
      io_cyc(16'h00f3, ~mdl[3] & 8'h5f, 1'b0);
      ce <= 1'b1;
      rd_reg(8'h03, mdl[3]);
      $display("enable test done");
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(8'h00, {4'h0, opt[i][23:20]});
         wr_reg(8'h12, {6'h00, opt[i][25:24]});
         chk({option_valid, total_mem_mb, bank_size}, opt[i][19:0]);
      end
      $display("option test done");
      for (int i = 0; i < 5; i++)
      begin
         wr_reg(8'h02, sh[i][31:24]);
         cpu_mem_valid <= 1'b1;
         cpu_mem_write <= sh[i][3];
         cpu_mem_addr <= sh[i][23:4];
         @(posedge ref_clk);
         cpu_mem_valid <= 1'b0;
         #1;
         chk({shadow_hit_ff, shadow_cacheable_ff, shadow_wr_block_ff},
            sh[i][2:0]);
      end
      $display("shadow test done");
      stop_test();
   end
endmodule
`default_nettype wire
